// [design/adt_timer.sv]
// Purpose: 32-bit down-counting timer with AXI4-Lite register slave
// Assumes: Inputs synchronous to clk_sys_in; gated register clock given as an enable
// Notes: Bus answers one cycle after acceptance, always OKAY
`timescale 1ns/1ps
module adt_timer import adt_pkg::*; #(
    parameter int ADDR_W = 12,
    parameter logic [11:0] PART_NUM = 12'h5a3, // Arbitrary value
    parameter logic [6:0] JEDEC_ID = 7'h2c, // Arbitrary value
    parameter logic [3:0] JEDEC_CONT = 4'h3, // Arbitrary value
    parameter logic [3:0] REVISION = 4'h1, // Arbitrary value
    parameter logic [3:0] CUST_MOD = 4'h0, // Arbitrary value
    parameter logic [31:0] COMP_ID = 32'h6e_a7_3c_42 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Register clock gate and strap pins
    input wire logic gated_register_clock_en_in,
    input wire logic [3:0] eco_revision_in,
    // Timer pins
    input wire logic external_count_input_in,
    output logic timer_irq_out,
    // AXI4-Lite write address
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [ADDR_W-1:0] awaddr_in,
    // AXI4-Lite write data
    input wire logic wvalid_in,
    output logic wready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    // AXI4-Lite write response
    output logic bvalid_out,
    input wire logic bready_in,
    output logic [1:0] bresp_out,
    // AXI4-Lite read address
    input wire logic arvalid_in,
    output logic arready_out,
    input wire logic [ADDR_W-1:0] araddr_in,
    // AXI4-Lite read data
    output logic rvalid_out,
    input wire logic rready_in,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out
);

    generate
        if (ADDR_W < 12) begin : g_addr_check
            $error("ADDR_W must be at least 12");
        end
    endgenerate

    adt_state_t q;
    adt_state_t d;

    logic wr_fire;
    logic rd_fire;
    logic [11:0] wr_ofs;
    logic dec;
    logic zero_hit;
    logic irq_clr;
    logic wr_value;

    // Byte-lane merge for write strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Read decode; unmapped words read as zero
    function automatic logic [31:0] read_word(input logic [11:0] ofs, input adt_state_t s,
                                              input logic [3:0] eco);
        logic [31:0] r;
        r = 32'h0000_0000;
        case ({ofs[11:2], 2'b00})
            ADT_OFS_CTRL: r = {28'h0000000, s.ctrl};
            ADT_OFS_VALUE: r = s.value;
            ADT_OFS_RELOAD: r = s.reload;
            ADT_OFS_IRQ: r = {31'h00000000, s.irq};
            ADT_OFS_PID4: r = {24'h000000, 4'h0, JEDEC_CONT}; // R11
            ADT_OFS_PID0: r = {24'h000000, PART_NUM[7:0]}; // R11
            ADT_OFS_PID1: r = {24'h000000, JEDEC_ID[3:0], PART_NUM[11:8]}; // R11
            ADT_OFS_PID2: r = {24'h000000, REVISION, 1'b1, JEDEC_ID[6:4]}; // R11
            ADT_OFS_PID3: r = {24'h000000, eco, CUST_MOD}; // R12
            ADT_OFS_CID0: r = {24'h000000, COMP_ID[7:0]};
            ADT_OFS_CID1: r = {24'h000000, COMP_ID[15:8]};
            ADT_OFS_CID2: r = {24'h000000, COMP_ID[23:16]};
            ADT_OFS_CID3: r = {24'h000000, COMP_ID[31:24]};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_word

    // Address and write data handshakes advance only while the register clock runs; B and R responses retire regardless
    assign awready_out = gated_register_clock_en_in && !q.bvalid
                         && awvalid_in && wvalid_in; // R8 R16
    assign wready_out = awready_out;
    assign arready_out = gated_register_clock_en_in && !q.rvalid; // R8 R16
    assign wr_fire = awready_out;
    assign rd_fire = arvalid_in && arready_out;
    assign wr_ofs = {awaddr_in[11:2], 2'b00};
    assign wr_value = wr_fire && wr_ofs == ADT_OFS_VALUE;
    assign irq_clr = wr_fire && wr_ofs == ADT_OFS_IRQ && wstrb_in[0] && wdata_in[0]; // R15

    // Count qualifier: level enable or edge clock from synchronised input
    always_comb begin
        dec = q.ctrl[ADT_CTRL_EN]; // R9
        if (q.ctrl[ADT_CTRL_EXT_EN] && !q.ext_s2) begin
            dec = 1'b0; // R4 R18
        end
        if (q.ctrl[ADT_CTRL_EXT_CLK] && !(q.ext_s2 && !q.ext_prev)) begin
            dec = 1'b0; // R6
        end
    end

    assign zero_hit = dec && q.value == ADT_ONE; // R2

    always_comb begin
        d = q;
        d.ext_s1 = external_count_input_in; // R6 R18
        d.ext_s2 = q.ext_s1;
        d.ext_prev = q.ext_s2;
        if (dec) begin
            if (q.value == 32'h0000_0000) begin
                d.value = q.reload; // R14
            end else begin
                d.value = q.value - ADT_ONE; // R1
            end
        end
        if (irq_clr) begin
            d.irq = 1'b0; // R3
        end
        if (zero_hit) begin
            d.irq = 1'b1; // R2 R5
        end
        if (wr_fire) begin
            case (wr_ofs)
                ADT_OFS_CTRL: begin
                    if (wstrb_in[0]) begin
                        d.ctrl = wdata_in[3:0]; // R13
                    end
                end
                ADT_OFS_VALUE: d.value = merge(q.value, wdata_in, wstrb_in);
                ADT_OFS_RELOAD: d.reload = merge(q.reload, wdata_in, wstrb_in); // R14
                default: d.ctrl = q.ctrl;
            endcase
            d.bvalid = 1'b1; // R16
        end else if (bready_in) begin
            d.bvalid = 1'b0;
        end
        if (rd_fire) begin
            d.rvalid = 1'b1; // R16
            d.rdata = read_word(araddr_in[11:0], q, eco_revision_in);
        end else if (rready_in) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q.ctrl <= ADT_RST_CTRL;
            q.value <= ADT_RST_VALUE;
            q.reload <= ADT_RST_RELOAD;
            q.irq <= 1'b0;
            q.ext_s1 <= 1'b0;
            q.ext_s2 <= 1'b0;
            q.ext_prev <= 1'b0;
            q.bvalid <= 1'b0;
            q.rvalid <= 1'b0;
            q.rdata <= 32'h0000_0000;
        end else begin
            q <= d;
        end
    end

    assign timer_irq_out = q.irq && q.ctrl[ADT_CTRL_IRQ_EN]; // R17
    assign bvalid_out = q.bvalid;
    assign bresp_out = ADT_RESP_OKAY; // R16
    assign rvalid_out = q.rvalid;
    assign rdata_out = q.rdata;
    assign rresp_out = ADT_RESP_OKAY; // R16

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    property p_count_down;
        dec && q.value != 32'h0000_0000 && !wr_value |=> q.value == $past(q.value) - ADT_ONE;
    endproperty
    a_count_down: assert property (p_count_down) else $error("count did not step down"); // R1

    property p_zero_sets;
        dec && q.value == ADT_ONE |=> q.irq;
    endproperty
    a_zero_sets: assert property (p_zero_sets) else $error("zero did not set status"); // R2

    property p_irq_holds;
        q.irq && !irq_clr |=> q.irq;
    endproperty
    a_irq_holds: assert property (p_irq_holds) else $error("status fell without clear"); // R3

    property p_set_beats_clear;
        irq_clr && zero_hit |=> q.irq ##1 (q.irq || $past(irq_clr));
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat zero"); // R5

    property p_clear_works;
        irq_clr && !zero_hit |=> !q.irq;
    endproperty
    a_clear_works: assert property (p_clear_works) else $error("clear ignored"); // R15

    property p_reload;
        dec && q.value == 32'h0000_0000 && !wr_value |=> q.value == $past(q.reload);
    endproperty
    a_reload: assert property (p_reload) else $error("reload not taken"); // R14

    property p_irq_out;
        q.irq && q.ctrl[ADT_CTRL_IRQ_EN] |-> timer_irq_out;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("irq output mismatch"); // R17

    property p_irq_out_off;
        !q.irq || !q.ctrl[ADT_CTRL_IRQ_EN] |-> !timer_irq_out;
    endproperty
    a_irq_out_off: assert property (p_irq_out_off) else $error("irq output not masked"); // R17

    property p_write_answer;
        awvalid_in && awready_out |=> bvalid_out && bresp_out == ADT_RESP_OKAY;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write answer late"); // R16

    property p_read_answer;
        arvalid_in && arready_out |=> rvalid_out && rresp_out == ADT_RESP_OKAY;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late"); // R16

    property p_gate_stops_bus;
        !gated_register_clock_en_in |-> !awready_out && !arready_out;
    endproperty
    a_gate_stops_bus: assert property (p_gate_stops_bus) else $error("bus moved while gated"); // R8

    property p_ext_clk_edge;
        q.ctrl == 4'h5 && !q.ext_s2
            ##1 q.ctrl == 4'h5 && q.ext_s2 && !wr_value && q.value > ADT_ONE
            |=> q.value == $past(q.value) - ADT_ONE;
    endproperty
    a_ext_clk_edge: assert property (p_ext_clk_edge) else $error("edge not counted"); // R6

    // Synchroniser and counting qualifiers
    property p_sync_first;
        nrst_in |=> q.ext_s1 == $past(external_count_input_in);
    endproperty
    a_sync_first: assert property (p_sync_first) else $error("first stage missed input"); // R18

    property p_sync_second;
        nrst_in |=> q.ext_s2 == $past(q.ext_s1);
    endproperty
    a_sync_second: assert property (p_sync_second) else $error("second stage missed"); // R6

    property p_ext_en_stall;
        q.ctrl[ADT_CTRL_EXT_EN] && !q.ext_s2 && !wr_value |=> q.value == $past(q.value);
    endproperty
    a_ext_en_stall: assert property (p_ext_en_stall) else $error("counted while input low"); // R4

    property p_ext_en_count;
        q.ctrl[ADT_CTRL_EN] && q.ctrl[ADT_CTRL_EXT_EN] && !q.ctrl[ADT_CTRL_EXT_CLK] && q.ext_s2
            && q.value > ADT_ONE && !wr_value |=> q.value == $past(q.value) - ADT_ONE;
    endproperty
    a_ext_en_count: assert property (p_ext_en_count) else $error("enabled count missed"); // R18

    property p_no_edge_hold;
        q.ctrl[ADT_CTRL_EXT_CLK] && !(q.ext_s2 && !q.ext_prev) && !wr_value
            |=> q.value == $past(q.value);
    endproperty
    a_no_edge_hold: assert property (p_no_edge_hold) else $error("counted without edge"); // R6

    property p_count_ungated;
        dec && !gated_register_clock_en_in && q.value != 32'h0000_0000
            |=> q.value == $past(q.value) - ADT_ONE;
    endproperty
    a_count_ungated: assert property (p_count_ungated) else $error("count stopped by gate"); // R9

    // Interrupt status
    property p_irq_only_zero;
        !q.irq && !zero_hit |=> !q.irq;
    endproperty
    a_irq_only_zero: assert property (p_irq_only_zero) else $error("status set without zero"); // R2

    property p_clear_needs_one;
        wr_fire && wr_ofs == ADT_OFS_IRQ && !wdata_in[0] && q.irq |=> q.irq;
    endproperty
    a_clear_needs_one: assert property (p_clear_needs_one) else $error("zero write cleared"); // R15

    // Bus handshakes, register writes and register reads
    property p_one_write;
        bvalid_out |-> !awready_out && !wready_out;
    endproperty
    a_one_write: assert property (p_one_write) else $error("second write taken"); // R16

    property p_one_read;
        rvalid_out |-> !arready_out;
    endproperty
    a_one_read: assert property (p_one_read) else $error("second read taken"); // R16

    property p_ready_needs_both;
        awready_out |-> awvalid_in && wvalid_in;
    endproperty
    a_ready_needs_both: assert property (p_ready_needs_both) else $error("half write taken"); // R16

    property p_ctrl_write;
        wr_fire && wr_ofs == ADT_OFS_CTRL && wstrb_in[0] |=> q.ctrl == $past(wdata_in[3:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // R13

    property p_ctrl_keep;
        wr_fire && wr_ofs == ADT_OFS_CTRL && !wstrb_in[0] |=> q.ctrl == $past(q.ctrl);
    endproperty
    a_ctrl_keep: assert property (p_ctrl_keep) else $error("control changed unstrobed"); // R13

    property p_reload_write;
        wr_fire && wr_ofs == ADT_OFS_RELOAD && wstrb_in == 4'hf |=> q.reload == $past(wdata_in);
    endproperty
    a_reload_write: assert property (p_reload_write) else $error("reload write lost"); // R14

    property p_value_write;
        wr_value && wstrb_in == 4'hf |=> q.value == $past(wdata_in);
    endproperty
    a_value_write: assert property (p_value_write) else $error("value write lost"); // R1

    property p_read_eco;
        rd_fire && {araddr_in[11:2], 2'b00} == ADT_OFS_PID3
            |=> rdata_out[7:4] == $past(eco_revision_in);
    endproperty
    a_read_eco: assert property (p_read_eco) else $error("revision pins not read"); // R12

    property p_read_status;
        rd_fire && {araddr_in[11:2], 2'b00} == ADT_OFS_IRQ
            |=> rdata_out == {31'h00000000, $past(q.irq)};
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong"); // R15

    property p_read_cid0;
        rd_fire && {araddr_in[11:2], 2'b00} == ADT_OFS_CID0
            |=> rdata_out == {24'h000000, COMP_ID[7:0]};
    endproperty
    a_read_cid0: assert property (p_read_cid0) else $error("component id read wrong"); // R11

endmodule : adt_timer

// [design/adt_pkg.sv]
// Purpose: Constants and state type for the down-counting timer with AXI4-Lite registers
// Assumes: One clock, synchronous inputs, 32-bit data bus
// Notes: Identification values are module parameters of the timer, except the ECO revision taken from input pins
// How it works
// R1: Counter is a 32-bit register counting down toward zero.
// R2: Interrupt status sets when a decrement brings the count to zero.
// R3: Interrupt stays set until software writes the clear register.
// R4: External input used as enable lets counting run only while it is high.
// R5: Zero event in the same cycle as a clear leaves status at one.
// R6: External clock mode uses two-flop synchroniser, edge detect, counts on edges.
// R7: External source keeps its input below half the system clock rate.
// R8: Register access only advances while the gated register clock enable is high.
// R9: Counting runs every system clock cycle regardless of register clock gating.
// R10: Integrator supplies gated register clock same rate, synchronous to system clock.
// R11: Optional read-only ID registers carry 12-bit part number and 7-bit JEDEC code.
// R12: ECO revision input pins read back in ID register 3 bits 7:4.
// R13: Control register at 0x000: irq enable, ext clock, ext enable, timer enable.
// R14: Reload value at 0x008 loads into the count after it reaches zero.
// R15: Interrupt status at 0x00C; writing one to bit 0 clears it.
// R16: Every transfer answers one cycle after acceptance, no waits, always OKAY.
// R17: Interrupt output high only while status and interrupt enable are both set.
// R18: External enable input passes the same two-flop synchroniser before use.
package adt_pkg;
    localparam logic [11:0] ADT_OFS_CTRL = 12'h000;
    localparam logic [11:0] ADT_OFS_VALUE = 12'h004;
    localparam logic [11:0] ADT_OFS_RELOAD = 12'h008;
    localparam logic [11:0] ADT_OFS_IRQ = 12'h00c;
    localparam logic [11:0] ADT_OFS_PID4 = 12'hfd0;
    localparam logic [11:0] ADT_OFS_PID5 = 12'hfd4;
    localparam logic [11:0] ADT_OFS_PID6 = 12'hfd8;
    localparam logic [11:0] ADT_OFS_PID7 = 12'hfdc;
    localparam logic [11:0] ADT_OFS_PID0 = 12'hfe0;
    localparam logic [11:0] ADT_OFS_PID1 = 12'hfe4;
    localparam logic [11:0] ADT_OFS_PID2 = 12'hfe8;
    localparam logic [11:0] ADT_OFS_PID3 = 12'hfec;
    localparam logic [11:0] ADT_OFS_CID0 = 12'hff0;
    localparam logic [11:0] ADT_OFS_CID1 = 12'hff4;
    localparam logic [11:0] ADT_OFS_CID2 = 12'hff8;
    localparam logic [11:0] ADT_OFS_CID3 = 12'hffc;

    localparam int ADT_CTRL_EN = 0;
    localparam int ADT_CTRL_EXT_EN = 1;
    localparam int ADT_CTRL_EXT_CLK = 2;
    localparam int ADT_CTRL_IRQ_EN = 3;

    localparam logic [3:0] ADT_RST_CTRL = 4'h0;
    localparam logic [31:0] ADT_RST_VALUE = 32'h0000_0000;
    localparam logic [31:0] ADT_RST_RELOAD = 32'h0000_0000;
    localparam logic [31:0] ADT_ONE = 32'h0000_0001;
    localparam logic [1:0] ADT_RESP_OKAY = 2'h0;

    typedef struct packed {
        logic [3:0] ctrl;
        logic [31:0] value;
        logic [31:0] reload;
        logic irq;
        logic ext_s1;
        logic ext_s2;
        logic ext_prev;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
    } adt_state_t;
endpackage : adt_pkg

// [verif/adt_axil_master.sv]
// Purpose: AXI4-Lite master model for the timer registers
// Assumes: One write and one read at most under way
// Notes: Released lines show the inverse of their last value
`timescale 1ns/1ps
module adt_axil_master (
    // Clock
    input wire logic clk_in,
    // Write channels
    output logic awvalid_out,
    output logic [11:0] awaddr_out,
    output logic wvalid_out,
    output logic [31:0] wdata_out,
    output logic [3:0] wstrb_out,
    output logic bready_out,
    input wire logic awready_in,
    input wire logic wready_in,
    input wire logic bvalid_in,
    input wire logic [1:0] bresp_in,
    // Read channels
    output logic arvalid_out,
    output logic [11:0] araddr_out,
    output logic rready_out,
    input wire logic arready_in,
    input wire logic rvalid_in,
    input wire logic [31:0] rdata_in,
    input wire logic [1:0] rresp_in
);
    initial begin
        {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
        {awaddr_out, araddr_out, wdata_out} = 56'h0;
        wstrb_out = 4'hf;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic ad;
        logic dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge clk_in);
        awvalid_out <= 1'b1;
        awaddr_out <= a;
        wvalid_out <= 1'b1;
        wdata_out <= d;
        wstrb_out <= s;
        bready_out <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk_in);
            if (!ad && awready_in) begin
                awvalid_out <= 1'b0;
                awaddr_out <= ~a;
                ad = 1'b1;
            end
            if (!dd && wready_in) begin
                wvalid_out <= 1'b0;
                wdata_out <= ~d;
                wstrb_out <= ~s;
                dd = 1'b1;
            end
        end
        do @(posedge clk_in); while (!bvalid_in);
        r = bresp_in;
        bready_out <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        arvalid_out <= 1'b1;
        araddr_out <= a;
        rready_out <= 1'b1;
        do @(posedge clk_in); while (!arready_in);
        arvalid_out <= 1'b0;
        araddr_out <= ~a;
        do @(posedge clk_in); while (!rvalid_in);
        d = rdata_in;
        r = rresp_in;
        rready_out <= 1'b0;
    endtask : rd
endmodule : adt_axil_master

// [verif/adt_timer_tb.sv]
// Purpose: Self-checking bench of the down-counting timer
// Assumes: Register clock enable in step with the system clock
// Notes: Identity parameters below are arbitrary values
`timescale 1ns/1ps
module adt_timer_tb import adt_pkg::*;;
    localparam logic [11:0] P_NUM = 12'h3c7; // Arbitrary value
    localparam logic [6:0] J_ID = 7'h15; // Arbitrary value
    localparam logic [3:0] P_REV = 4'h2; // Arbitrary value
    localparam logic [3:0] J_CONT = 4'h6; // Arbitrary value
    localparam logic [3:0] C_MOD = 4'h9; // Arbitrary value
    localparam logic [31:0] C_ID = 32'h5d_3a_91_c6; // Arbitrary value
    logic clk, nrst, gate, ext, irq, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
    logic [3:0] eco, ws;
    logic [11:0] awa, ara;
    logic [31:0] wd, rd;
    logic [1:0] bre, rre;
    int miscompares = 0;
    int samples_checked = 0;

    adt_timer #(.PART_NUM(P_NUM), .JEDEC_ID(J_ID), .REVISION(P_REV), .JEDEC_CONT(J_CONT),
        .CUST_MOD(C_MOD), .COMP_ID(C_ID)) i_adt_timer (
        .clk_sys_in(clk), .nrst_in(nrst), .gated_register_clock_en_in(gate),
        .eco_revision_in(eco), .external_count_input_in(ext), .timer_irq_out(irq),
        .awvalid_in(awv), .awready_out(awr), .awaddr_in(awa), .wvalid_in(wv),
        .wready_out(wrdy), .wdata_in(wd), .wstrb_in(ws), .bvalid_out(bv), .bready_in(br),
        .bresp_out(bre), .arvalid_in(arv), .arready_out(arr), .araddr_in(ara),
        .rvalid_out(rv), .rready_in(rr), .rdata_out(rd), .rresp_out(rre));
    adt_axil_master i_adt_axil_master (
        .clk_in(clk), .awvalid_out(awv), .awaddr_out(awa), .wvalid_out(wv),
        .wdata_out(wd), .wstrb_out(ws), .bready_out(br), .awready_in(awr),
        .wready_in(wrdy), .bvalid_in(bv), .bresp_in(bre), .arvalid_out(arv),
        .araddr_out(ara), .rready_out(rr), .arready_in(arr), .rvalid_in(rv),
        .rdata_in(rd), .rresp_in(rre));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] r;
        i_adt_axil_master.rd(a, v, r);
        chk(n, v, e);
        chk("rresp", {30'h0, r}, {30'h0, ADT_RESP_OKAY});
    endtask : rc
    task automatic wl(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        i_adt_axil_master.wr(a, d, s, r);
        chk("bresp", {30'h0, r}, {30'h0, ADT_RESP_OKAY});
    endtask : wl
    task automatic wc(input logic [11:0] a, input logic [31:0] d);
        wl(a, d, 4'hf);
    endtask : wc
    // Input high for k cycles, then settle; slow against the clock
    task automatic pulse(input int k);
        @(posedge clk);
        ext <= 1'b1;
        repeat (k) @(posedge clk);
        ext <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic t_regs();
        rc("ctrl", ADT_OFS_CTRL, 32'h0);
        rc("value", ADT_OFS_VALUE, 32'h0);
        rc("status", ADT_OFS_IRQ, 32'h0);
        rc("pid0", ADT_OFS_PID0, {24'h0, P_NUM[7:0]});
        rc("pid1", ADT_OFS_PID1, {24'h0, J_ID[3:0], P_NUM[11:8]});
        rc("pid2", ADT_OFS_PID2, {24'h0, P_REV, 1'b1, J_ID[6:4]});
        rc("pid3", ADT_OFS_PID3, {24'h0, eco, C_MOD});
        rc("pid4", ADT_OFS_PID4, {24'h0, 4'h0, J_CONT});
        rc("cid0", ADT_OFS_CID0, {24'h0, C_ID[7:0]});
        rc("cid3", ADT_OFS_CID3, {24'h0, C_ID[31:24]});
        wl(ADT_OFS_RELOAD, 32'haabb_ccdd, 4'h5);
        rc("lanes", ADT_OFS_RELOAD, 32'h00bb_00dd);
        wl(ADT_OFS_CTRL, 32'hf, 4'he);
        rc("ctrl_lane", ADT_OFS_CTRL, 32'h0);
        wc(12'h010, 32'hffff_ffff);
        rc("unmapped", 12'h010, 32'h0);
    endtask : t_regs
    task automatic t_ext_en();
        wc(ADT_OFS_RELOAD, 32'h7);
        wc(ADT_OFS_VALUE, 32'ha);
        wc(ADT_OFS_CTRL, 32'hb);
        rc("held", ADT_OFS_VALUE, 32'ha);
        pulse(4);
        rc("counted", ADT_OFS_VALUE, 32'h6);
        pulse(6);
        chk("irq_out", {31'h0, irq}, 32'h1);
        rc("status", ADT_OFS_IRQ, 32'h1);
        pulse(3);
        rc("reloaded", ADT_OFS_VALUE, 32'h5);
        wc(ADT_OFS_CTRL, 32'h3);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wc(ADT_OFS_IRQ, 32'h0);
        rc("sticky", ADT_OFS_IRQ, 32'h1);
    endtask : t_ext_en
    // Clear write released by the enable exactly at the zero edge
    task automatic t_clash();
        wc(ADT_OFS_RELOAD, 32'hffff);
        wc(ADT_OFS_CTRL, 32'h9);
        wc(ADT_OFS_VALUE, 32'h8);
        gate <= 1'b0;
        fork
            wc(ADT_OFS_IRQ, 32'h1);
            begin
                repeat (3) @(posedge clk);
                chk("stalled", {31'h0, awr}, 32'h0);
                repeat (3) @(posedge clk);
                gate <= 1'b1;
            end
        join
        rc("zero_wins", ADT_OFS_IRQ, 32'h1);
        wc(ADT_OFS_IRQ, 32'h1);
        rc("cleared", ADT_OFS_IRQ, 32'h0);
        chk("irq_low", {31'h0, irq}, 32'h0);
    endtask : t_clash
    task automatic t_ext_clk();
        wc(ADT_OFS_CTRL, 32'h5);
        wc(ADT_OFS_VALUE, 32'h14);
        repeat (3) pulse(6);
        rc("edges", ADT_OFS_VALUE, 32'h11);
    endtask : t_ext_clk

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        nrst = 1'b0;
        gate = 1'b1;
        ext = 1'b0;
        eco = 4'ha;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_ext_en();
        t_clash();
        t_ext_clk();
        report_and_stop();
    end
endmodule : adt_timer_tb
